// ==== ocs_clock_sel_regs.vh ====
`ifndef OCS_CLOCK_SEL_REGS_VH
`define OCS_CLOCK_SEL_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OCS_ADDR_W 12
`define OCS_OFS_CONTROL 12'h000
`define OCS_OFS_TUNING 12'h004
`define OCS_OFS_FEATURE 12'h008
`define OCS_OFS_STATUS 12'h00c

////////////////////////////////////////////////////////////////////////////////
// field positions
`define OCS_CTL_IFS_HI 6
`define OCS_CTL_IFS_LO 4
`define OCS_TUN_SRC_BIT 7
`define OCS_TUN_VAL_HI 4
`define OCS_TUN_VAL_LO 0
`define OCS_FEAT_W 4
`define OCS_FEAT_PWRT 0
`define OCS_FEAT_FSCM 1
`define OCS_FEAT_WDT 2
`define OCS_FEAT_TWOSPD 3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define OCS_RST_IFS 3'h6
`define OCS_RST_TUNE 5'h00
`define OCS_RST_SRC 1'h0
`define OCS_RST_FEAT 4'h0

////////////////////////////////////////////////////////////////////////////////
// oscillator mode codes
`define OCS_MODE_XT 4'h0
`define OCS_MODE_CRYSTAL_LOW_MULT_MODE 4'h1
`define OCS_MODE_HS 4'h2
`define OCS_MODE_CRYSTAL_HIGH_MULT_MODE 4'h3
`define OCS_MODE_EC 4'h4
`define OCS_MODE_EXTERNAL_CLOCK_PIN_IO_MODE 4'h5
`define OCS_MODE_EXTERNAL_CLOCK_MULT_MODE 4'h6
`define OCS_MODE_EXTERNAL_CLOCK_MULT_PIN_MODE 4'h7
`define OCS_MODE_INTERNAL_USB_HIGH_CRYSTAL_MODE 4'h8
`define OCS_MODE_INTERNAL_USB_LOW_CRYSTAL_MODE 4'h9
`define OCS_MODE_INTERNAL_PIN_IO_MODE 4'ha
`define OCS_MODE_INTERNAL_CLOCKOUT_MODE 4'hb

////////////////////////////////////////////////////////////////////////////////
// internal frequency select codes
`define OCS_IFS_SLOW 3'h0
`define OCS_IFS_FAST 3'h7

////////////////////////////////////////////////////////////////////////////////
// divider ratios
`define OCS_DIV_W 9
`define OCS_DIV_LOWSRC 9'h100
`define OCS_DIV_CLKOUT_HALF 9'h002
`define OCS_TUNE_MAX 5'h0f
`define OCS_TUNE_MIN 5'h10

////////////////////////////////////////////////////////////////////////////////
// timing
`define OCS_CLK_HZ 10000000
`define OCS_FAST_SETTLE_US 1000
`define OCS_TUNE_SPAN 32
`define OCS_SLOW_SETTLE_TICKS 8

`endif

// ==== ocs_tick_div.v ====
`include "ocs_clock_sel_regs.vh"

// divides a tick stream by a run-time ratio; output period stays uniform
module ocs_tick_div #(
	parameter W = `OCS_DIV_W
) (
	input wire clk,
	input wire arst_n,
	input wire tickIn,
	input wire [W-1:0] divisor,
	output reg tickOut
);

	reg [W-1:0] count_ff;
	wire [W-1:0] lastCount;

	assign lastCount = (divisor == {W{1'b0}}) ? {W{1'b0}} : divisor - {{(W-1){1'b0}}, 1'b1};

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_ff <= {W{1'b0}};
			tickOut <= 1'b0;
		end else begin
			tickOut <= 1'b0;
			if (tickIn) begin
				if (count_ff >= lastCount) begin
					count_ff <= {W{1'b0}};
					tickOut <= 1'b1;
				end else begin
					count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // ocs_tick_div

// ==== ocs_clock_sel.v ====
// Local design decisions: the APB slave port and the register offsets.
`include "ocs_clock_sel_regs.vh"

// Summary of operation
// - crystal modes without multiplier: cpu clock is oscillator divided 1, 2, 3 or 4
// - plain and multiplier external-clock modes drive output pin with cpu clock/4
// - the two external-clock io modes turn output pin into port a bit 6
// - external-clock modes request no oscillator start-up delay
// - crystal cpu postscaler also serves plain and io external-clock modes
// - multiplier enabled only in four multiplier modes, 4 MHz in to 96 MHz
// - multiplier input prescaler, eight ratios up to twelve, feeds 4 MHz; fixed at 1 in crystal low mult mode
// - cpu from multiplier: 96 MHz divided by 2, 3, 4 or 6
// - fast internal oscillator 8 MHz can directly clock the device
// - fast oscillator postscaler gives device clocks from 31 kHz to 4 MHz
// - fast oscillator runs when selected frequency is 125 kHz to 8 MHz, or when source bit is set
// - slow oscillator runs when chosen or any of four special features enabled
// - internal frequency select picks fast direct, slow direct or postscaled fast
// - internal cpu clock: usb clock taken from mode's external oscillator source
// - two internal crystal modes run oscillator in high or low crystal drive
// - internal clock-out mode: usb from external clock, pin drives cpu/4
// - internal io mode: usb from external clock, pin is port io
// - after tuning write slow settles within 8 ticks, fast within 1 ms
// - execution continues during tuning shift, no completion flag
// - tuning uses constant step per code across the range
// - low-frequency source bit picks which oscillator gives 31 kHz option
// - source bit set: fast oscillator/256; clear: slow oscillator directly
// - tuning field two's complement: 00000 centre, 01111 max, 10000 min
// - mode, prescale and postscale settings taken from straps once after reset, fixed until next reset
module ocs_clock_sel #(
	parameter CLK_HZ = `OCS_CLK_HZ,
	parameter FAST_SETTLE_US = `OCS_FAST_SETTLE_US
) (
	input wire clk,
	input wire arst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`OCS_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [3:0] oscModeSelStrap,
	input wire [1:0] cpuPostscaleSelStrap,
	input wire [2:0] multPrescaleSelStrap,
	input wire oscInTick,
	input wire multRefTick,
	input wire fastOscTick,
	input wire slowOscTick,
	input wire portBit6Out,
	input wire portBit6OutEn,
	input wire oscOutPinI,
	output reg oscOutPinO,
	output reg oscOutPinOe,
	output reg portBit6In,
	output reg cpuClkTick,
	output reg usbSrcTick,
	output reg multEnable,
	output reg multInTick,
	output reg fastOscEnable,
	output reg slowOscEnable,
	output reg oscAmpEnable,
	output reg oscHighDrive,
	output reg startupDelayEn,
	output reg [4:0] fastTrim,
	output reg [4:0] slowTrim
);

	////////////////////////////////////////////////////////////////////////////
	// derived timing
	localparam integer FAST_SETTLE_CYC = (CLK_HZ / 1000000) * FAST_SETTLE_US;
	localparam integer STEP_CYC_RAW = FAST_SETTLE_CYC / `OCS_TUNE_SPAN;
	localparam integer STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
	localparam [31:0] STEP_LAST_FULL = STEP_CYC - 1;
	localparam [15:0] STEP_LAST = STEP_LAST_FULL[15:0];

	////////////////////////////////////////////////////////////////////////////
	// decode functions
	function isMultMode;
		input [3:0] m;
		begin
			isMultMode = (m == `OCS_MODE_CRYSTAL_LOW_MULT_MODE) || (m == `OCS_MODE_CRYSTAL_HIGH_MULT_MODE) ||
				(m == `OCS_MODE_EXTERNAL_CLOCK_MULT_MODE) || (m == `OCS_MODE_EXTERNAL_CLOCK_MULT_PIN_MODE);
		end
	endfunction

	function isIntMode;
		input [3:0] m;
		begin
			isIntMode = (m == `OCS_MODE_INTERNAL_USB_HIGH_CRYSTAL_MODE) || (m == `OCS_MODE_INTERNAL_USB_LOW_CRYSTAL_MODE) ||
				(m == `OCS_MODE_INTERNAL_PIN_IO_MODE) || (m == `OCS_MODE_INTERNAL_CLOCKOUT_MODE);
		end
	endfunction

	function isExtClkMode;
		input [3:0] m;
		begin
			isExtClkMode = (m == `OCS_MODE_EC) || (m == `OCS_MODE_EXTERNAL_CLOCK_PIN_IO_MODE) ||
				(m == `OCS_MODE_EXTERNAL_CLOCK_MULT_MODE) || (m == `OCS_MODE_EXTERNAL_CLOCK_MULT_PIN_MODE) ||
				(m == `OCS_MODE_INTERNAL_PIN_IO_MODE) || (m == `OCS_MODE_INTERNAL_CLOCKOUT_MODE);
		end
	endfunction

	function isPinIoMode;
		input [3:0] m;
		begin
			isPinIoMode = (m == `OCS_MODE_EXTERNAL_CLOCK_PIN_IO_MODE) || (m == `OCS_MODE_EXTERNAL_CLOCK_MULT_PIN_MODE) ||
				(m == `OCS_MODE_INTERNAL_PIN_IO_MODE);
		end
	endfunction

	function isClkOutMode;
		input [3:0] m;
		begin
			isClkOutMode = (m == `OCS_MODE_EC) || (m == `OCS_MODE_EXTERNAL_CLOCK_MULT_MODE) ||
				(m == `OCS_MODE_INTERNAL_CLOCKOUT_MODE);
		end
	endfunction

	function isHighDriveMode;
		input [3:0] m;
		begin
			isHighDriveMode = (m == `OCS_MODE_HS) || (m == `OCS_MODE_CRYSTAL_HIGH_MULT_MODE) ||
				(m == `OCS_MODE_INTERNAL_USB_HIGH_CRYSTAL_MODE);
		end
	endfunction

	// internal frequency select to fast-oscillator divide ratio
	function [`OCS_DIV_W-1:0] intDivisor;
		input [2:0] sel;
		begin
			case (sel)
				3'h7: intDivisor = 9'h001;
				3'h6: intDivisor = 9'h002;
				3'h5: intDivisor = 9'h004;
				3'h4: intDivisor = 9'h008;
				3'h3: intDivisor = 9'h010;
				3'h2: intDivisor = 9'h020;
				3'h1: intDivisor = 9'h040;
				default: intDivisor = `OCS_DIV_LOWSRC;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration caught once after reset release
	reg cfgLoaded_ff;
	reg [3:0] mode_ff;
	reg [1:0] cpuSel_ff;
	reg [2:0] preSel_ff;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfgLoaded_ff <= 1'b0;
			mode_ff <= `OCS_MODE_XT;
			cpuSel_ff <= 2'h0;
			preSel_ff <= 3'h0;
		end else if (!cfgLoaded_ff) begin
			cfgLoaded_ff <= 1'b1;
			mode_ff <= oscModeSelStrap;
			cpuSel_ff <= cpuPostscaleSelStrap;
			preSel_ff <= multPrescaleSelStrap;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	reg [2:0] intFreqSel_ff;
	reg lowSrcSel_ff;
	reg [4:0] tuneVal_ff;
	reg [`OCS_FEAT_W-1:0] feat_ff;
	reg [31:0] nxt_rdata;
	reg nxt_err;
	wire access;
	wire wrDone;

	assign access = psel && penable && !pready;
	assign wrDone = psel && penable && pready && pwrite && !pslverr;

	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_err = 1'b0;
		case (paddr)
			`OCS_OFS_CONTROL: nxt_rdata[`OCS_CTL_IFS_HI:`OCS_CTL_IFS_LO] = intFreqSel_ff;
			`OCS_OFS_TUNING: begin
				nxt_rdata[`OCS_TUN_SRC_BIT] = lowSrcSel_ff;
				nxt_rdata[`OCS_TUN_VAL_HI:`OCS_TUN_VAL_LO] = tuneVal_ff;
			end
			`OCS_OFS_FEATURE: nxt_rdata[`OCS_FEAT_W-1:0] = feat_ff;
			`OCS_OFS_STATUS: nxt_rdata[12:0] = {multEnable, fastOscEnable, slowOscEnable,
				startupDelayEn, mode_ff, cpuSel_ff, preSel_ff};
			default: nxt_err = 1'b1;
		endcase
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			pslverr <= access && nxt_err;
			if (access && !pwrite) begin
				prdata <= nxt_rdata;
			end
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			intFreqSel_ff <= `OCS_RST_IFS;
			lowSrcSel_ff <= `OCS_RST_SRC;
			tuneVal_ff <= `OCS_RST_TUNE;
			feat_ff <= `OCS_RST_FEAT;
		end else if (wrDone) begin
			case (paddr)
				`OCS_OFS_CONTROL: intFreqSel_ff <= pwdata[`OCS_CTL_IFS_HI:`OCS_CTL_IFS_LO];
				`OCS_OFS_TUNING: begin
					lowSrcSel_ff <= pwdata[`OCS_TUN_SRC_BIT];
					tuneVal_ff <= pwdata[`OCS_TUN_VAL_HI:`OCS_TUN_VAL_LO];
				end
				`OCS_OFS_FEATURE: feat_ff <= pwdata[`OCS_FEAT_W-1:0];
				default: feat_ff <= feat_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// dividers
	reg [`OCS_DIV_W-1:0] preDiv;
	reg [`OCS_DIV_W-1:0] multPostDiv;
	reg [`OCS_DIV_W-1:0] intDiv;
	wire [`OCS_DIV_W-1:0] primPostDiv;
	wire preTick;
	wire primPostTick;
	wire multPostTick;
	wire intPostTick;
	wire halfOutTick;

	assign primPostDiv = {7'h00, cpuSel_ff} + 9'h001;

	always @* begin
		case (preSel_ff)
			3'h0: preDiv = 9'h001;
			3'h1: preDiv = 9'h002;
			3'h2: preDiv = 9'h003;
			3'h3: preDiv = 9'h004;
			3'h4: preDiv = 9'h005;
			3'h5: preDiv = 9'h006;
			3'h6: preDiv = 9'h00a;
			default: preDiv = 9'h00c;
		endcase
		if (mode_ff == `OCS_MODE_CRYSTAL_LOW_MULT_MODE) begin
			preDiv = 9'h001;
		end
		case (cpuSel_ff)
			2'h0: multPostDiv = 9'h002;
			2'h1: multPostDiv = 9'h003;
			2'h2: multPostDiv = 9'h004;
			default: multPostDiv = 9'h006;
		endcase
		intDiv = intDivisor(intFreqSel_ff);
	end

	ocs_tick_div u_preDiv (
		.clk(clk),
		.arst_n(arst_n),
		.tickIn(oscInTick),
		.divisor(preDiv),
		.tickOut(preTick)
	);

	ocs_tick_div u_primPost (
		.clk(clk),
		.arst_n(arst_n),
		.tickIn(oscInTick),
		.divisor(primPostDiv),
		.tickOut(primPostTick)
	);

	ocs_tick_div u_multPost (
		.clk(clk),
		.arst_n(arst_n),
		.tickIn(multRefTick),
		.divisor(multPostDiv),
		.tickOut(multPostTick)
	);

	ocs_tick_div u_intPost (
		.clk(clk),
		.arst_n(arst_n),
		.tickIn(fastOscTick),
		.divisor(intDiv),
		.tickOut(intPostTick)
	);

	ocs_tick_div u_clkOut (
		.clk(clk),
		.arst_n(arst_n),
		.tickIn(cpuClkTick),
		.divisor(`OCS_DIV_CLKOUT_HALF),
		.tickOut(halfOutTick)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock selection
	reg nxt_cpuTick;
	reg nxt_usbTick;
	reg nxt_intTick;
	reg clkOutLevel_ff;

	always @* begin
		if (intFreqSel_ff == `OCS_IFS_FAST) begin
			nxt_intTick = fastOscTick;
		end else if (intFreqSel_ff == `OCS_IFS_SLOW) begin
			nxt_intTick = lowSrcSel_ff ? intPostTick : slowOscTick;
		end else begin
			nxt_intTick = intPostTick;
		end
		if (isIntMode(mode_ff)) begin
			nxt_cpuTick = nxt_intTick;
		end else if (isMultMode(mode_ff)) begin
			nxt_cpuTick = multPostTick;
		end else begin
			nxt_cpuTick = primPostTick;
		end
		// usb path always from primary chain, multiplied where enabled
		nxt_usbTick = isMultMode(mode_ff) ? multRefTick : oscInTick;
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuClkTick <= 1'b0;
			usbSrcTick <= 1'b0;
			multInTick <= 1'b0;
			clkOutLevel_ff <= 1'b0;
		end else begin
			cpuClkTick <= cfgLoaded_ff && nxt_cpuTick;
			usbSrcTick <= cfgLoaded_ff && nxt_usbTick;
			multInTick <= isMultMode(mode_ff) && preTick;
			if (halfOutTick) begin
				clkOutLevel_ff <= !clkOutLevel_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// enables and oscillator pin
	wire slowChosen;

	assign slowChosen = isIntMode(mode_ff) && (intFreqSel_ff == `OCS_IFS_SLOW) && !lowSrcSel_ff;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			multEnable <= 1'b0;
			fastOscEnable <= 1'b0;
			slowOscEnable <= 1'b0;
			oscAmpEnable <= 1'b0;
			oscHighDrive <= 1'b0;
			startupDelayEn <= 1'b0;
			oscOutPinO <= 1'b0;
			oscOutPinOe <= 1'b0;
			portBit6In <= 1'b0;
		end else begin
			multEnable <= cfgLoaded_ff && isMultMode(mode_ff);
			// fast core also needed when it feeds the low-frequency option
			fastOscEnable <= (intFreqSel_ff != `OCS_IFS_SLOW) || lowSrcSel_ff;
			slowOscEnable <= slowChosen || (feat_ff != `OCS_RST_FEAT);
			oscAmpEnable <= cfgLoaded_ff && !isExtClkMode(mode_ff);
			oscHighDrive <= isHighDriveMode(mode_ff);
			startupDelayEn <= cfgLoaded_ff && !isExtClkMode(mode_ff);
			portBit6In <= isPinIoMode(mode_ff) ? oscOutPinI : 1'b0;
			if (isPinIoMode(mode_ff)) begin
				oscOutPinO <= portBit6Out;
				oscOutPinOe <= portBit6OutEn;
			end else if (isClkOutMode(mode_ff)) begin
				oscOutPinO <= clkOutLevel_ff;
				oscOutPinOe <= cfgLoaded_ff;
			end else begin
				oscOutPinO <= 1'b0;
				oscOutPinOe <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// tuning slew; runs in background and raises no flag
	reg [15:0] stepCnt_ff;
	reg [3:0] slowCnt_ff;
	wire stepNow;
	wire fastUp;

	assign stepNow = (stepCnt_ff == STEP_LAST);
	assign fastUp = $signed(tuneVal_ff) > $signed(fastTrim);

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stepCnt_ff <= 16'h0000;
			slowCnt_ff <= 4'h0;
			fastTrim <= `OCS_RST_TUNE;
			slowTrim <= `OCS_RST_TUNE;
		end else begin
			stepCnt_ff <= stepNow ? 16'h0000 : stepCnt_ff + 16'h0001;
			if (stepNow && (fastTrim != tuneVal_ff)) begin
				// one code per step: 31 steps fit in the settle time
				fastTrim <= fastUp ? fastTrim + 5'h01 : fastTrim - 5'h01;
			end
			if (wrDone && (paddr == `OCS_OFS_TUNING)) begin
				slowCnt_ff <= 4'h0;
			end else if (slowOscTick && (slowCnt_ff != `OCS_SLOW_SETTLE_TICKS)) begin
				slowCnt_ff <= slowCnt_ff + 4'h1;
				if (slowCnt_ff == `OCS_SLOW_SETTLE_TICKS - 1) begin
					slowTrim <= tuneVal_ff;
				end
			end
		end
	end

endmodule // ocs_clock_sel

// ==== ocs_clock_sel_asserts.sv ====
`include "ocs_clock_sel_regs.vh"
module ocs_clock_sel_asserts (
	input wire clk,
	input wire arst_n,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire [3:0] oscModeSelStrap,
	input wire oscInTick,
	input wire multRefTick,
	input wire usbSrcTick,
	input wire multEnable,
	input wire multInTick,
	input wire startupDelayEn,
	input wire oscOutPinOe
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [3:0] modeQ_ff;
	reg [1:0] cnt_ff;
	wire ok = cnt_ff == 2'h3;
	wire pll = modeQ_ff inside {4'h1, 4'h3, 4'h6, 4'h7};
	wire ec = modeQ_ff inside {[4'h4:4'h7]};
	wire ckOut = modeQ_ff inside {4'h4, 4'h6, 4'hb};
	wire xtal = modeQ_ff <= 4'h3;
	// mirror of the strap latch, settled from the third edge on
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 2'h0;
			modeQ_ff <= 4'h0;
		end else if (cnt_ff != 2'h3) begin
			cnt_ff <= cnt_ff + 2'h1;
			if (cnt_ff == 2'h0)
				modeQ_ff <= oscModeSelStrap;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_mult;
		ok |-> multEnable == pll;
	endproperty
	a_mult: assert property (p_mult) else $error("multiplier enable wrong");
	property p_mult_in;
		multInTick |-> multEnable;
	endproperty
	a_mult_in: assert property (p_mult_in) else $error("prescaler tick while off");
	property p_ec_start;
		ok && ec |-> !startupDelayEn;
	endproperty
	a_ec_start: assert property (p_ec_start) else $error("startup delay in ext clock");
	property p_xtal_start;
		ok && xtal |-> startupDelayEn;
	endproperty
	a_xtal_start: assert property (p_xtal_start) else $error("no crystal startup delay");
	property p_ck_out;
		ok && ckOut |-> oscOutPinOe;
	endproperty
	a_ck_out: assert property (p_ck_out) else $error("clock out pin not driven");
	property p_usb_pll;
		ok && pll && usbSrcTick |-> $past(multRefTick);
	endproperty
	a_usb_pll: assert property (p_usb_pll) else $error("usb tick not from multiplier");
	property p_usb_osc;
		ok && !pll && usbSrcTick |-> $past(oscInTick);
	endproperty
	a_usb_osc: assert property (p_usb_osc) else $error("usb tick not from osc");
	property p_ready;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not one wait state");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
endmodule // ocs_clock_sel_asserts
////////////////////////////////////////////////////////////////////////////////
bind ocs_clock_sel ocs_clock_sel_asserts u_asserts (.*);

// ==== ocs_osc_model.sv ====
module ocs_osc_model #(
	parameter OSC_PER = 7,
	parameter MULT_PER = 4,
	parameter FAST_PER = 3,
	parameter SLOW_PER = 11
) (
	input wire clk,
	output logic oscTick,
	output logic multTick,
	output logic fastTick,
	output logic slowTick
);
	timeunit 1ns;
	timeprecision 1ns;
	int c = 0;
	initial {oscTick, multTick, fastTick, slowTick} = 4'h0;
	// free-running sources; one osc period stands for the 4 MHz crystal
	always @(posedge clk) begin
		c <= c + 1;
		oscTick <= (c % OSC_PER) == 0;
		multTick <= (c % MULT_PER) == 0;
		fastTick <= (c % FAST_PER) == 0;
		slowTick <= (c % SLOW_PER) == 0;
	end
endmodule // ocs_osc_model

// ==== ocs_clock_sel_tb_top.sv ====
`include "ocs_clock_sel_regs.vh"
module ocs_clock_sel_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, er, extPin;
	logic portBit6Out, portBit6OutEn, oscInTick, multRefTick, fastOscTick, slowOscTick;
	logic oscOutPinO, oscOutPinOe, portBit6In, cpuClkTick, usbSrcTick, multEnable, multInTick;
	logic fastOscEnable, slowOscEnable, oscAmpEnable, oscHighDrive, startupDelayEn;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] oscModeSelStrap;
	logic [1:0] cpuPostscaleSelStrap;
	logic [2:0] multPrescaleSelStrap;
	logic [4:0] fastTrim, slowTrim;
	wire oscOutPinI = oscOutPinOe ? oscOutPinO : extPin;
	wire [3:0] tk = {oscOutPinO, multInTick, usbSrcTick, cpuClkTick};
	int nFail = 0;
	int totalChecks = 0;
	int p;
	// mode, cpu sel, prescale sel, then periods of cpu, usb, mult in, pin (0 skips)
	int rows[12][7] = '{'{0, 3, 0, 28, 7, 0, 0}, '{1, 1, 5, 12, 4, 7, 0},
		'{2, 0, 0, 7, 7, 0, 0}, '{3, 3, 2, 24, 4, 21, 0}, '{4, 1, 0, 14, 7, 0, 56},
		'{5, 2, 0, 21, 7, 0, 0}, '{6, 0, 7, 8, 4, 84, 32}, '{7, 2, 6, 16, 4, 70, 0},
		'{8, 0, 0, 6, 7, 0, 0}, '{9, 0, 0, 6, 7, 0, 0}, '{10, 0, 0, 6, 7, 0, 0},
		'{11, 0, 0, 6, 7, 0, 24}};
	ocs_clock_sel #(.FAST_SETTLE_US(32)) DUT (.*);
	ocs_osc_model u_osc (.clk(clk), .oscTick(oscInTick), .multTick(multRefTick),
		.fastTick(fastOscTick), .slowTick(slowOscTick));
	////////////////////////////////////////////////////////////////////////////
	task endOfTest;
		if (nFail == 0 && totalChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// request stands until pready is sampled high at a rising edge
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
			nFail++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task restart(input int m, input int cs, input int ps);
		@(posedge clk);
		arst_n <= 1'b0;
		oscModeSelStrap <= m[3:0];
		cpuPostscaleSelStrap <= cs[1:0];
		multPrescaleSelStrap <= ps[2:0];
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// cycles between two rises of one tick line
	task per(input int j, output int q);
		int k;
		logic prv;
		k = 0;
		prv = 1'b1;
		q = 0;
		repeat (4000) begin
			@(negedge clk);
			if (tk[j] && !prv) begin
				if (k > 0) begin
					q = k;
					break;
				end
				k = 1;
			end else if (k > 0)
				k++;
			prv = tk[j];
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		nFail++;
		endOfTest;
	end
	initial begin
		{arst_n, psel, penable, pwrite, portBit6Out, portBit6OutEn, extPin} = 7'h00;
		{paddr, pwdata} = 44'h0;
		{oscModeSelStrap, cpuPostscaleSelStrap, multPrescaleSelStrap} = 9'h000;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			restart(rows[i][0], rows[i][1], rows[i][2]);
			for (int j = 0; j < 4; j++)
				if (rows[i][3 + j] != 0) begin
					repeat (2) per(j, p);
					chk("tick period", p, rows[i][3 + j]);
				end
			chk("mult enable", multEnable, rows[i][0] inside {1, 3, 6, 7});
			chk("high drive", oscHighDrive, rows[i][0] inside {2, 3, 8});
			chk("amp and startup", {oscAmpEnable, startupDelayEn}, {2{!(rows[i][0] inside {[4:7], 10, 11})}});
		end
		restart(10, 0, 0);
		oscModeSelStrap <= 4'h4;
		repeat (2) per(0, p);
		chk("cpu after strap change", p, 6);
		apb(0, `OCS_OFS_CONTROL, 0);
		chk("control reset", rd, 32'h60);
		apb(0, `OCS_OFS_TUNING, 0);
		chk("tuning reset", rd, 0);
		apb(0, 12'h010, 0);
		chk("unmapped error", er, 1);
		chk("unmapped data", rd, 0);
		for (int s = 7; s >= 1; s--) begin
			apb(1, `OCS_OFS_CONTROL, s << 4);
			repeat (2) per(0, p);
			chk("fast postscale period", p, 3 << (7 - s));
			chk("fast enable", fastOscEnable, 1);
		end
		apb(1, `OCS_OFS_CONTROL, 0);
		repeat (2) per(0, p);
		chk("slow direct period", p, 11);
		chk("fast off", fastOscEnable, 0);
		chk("slow on", slowOscEnable, 1);
		apb(1, `OCS_OFS_TUNING, 32'h80);
		repeat (2) per(0, p);
		chk("fast div256 period", p, 768);
		chk("fast on", fastOscEnable, 1);
		apb(1, `OCS_OFS_CONTROL, 32'h70);
		repeat (3) @(negedge clk);
		chk("slow idle", slowOscEnable, 0);
		for (int b = 0; b < 4; b++) begin
			apb(1, `OCS_OFS_FEATURE, 1 << b);
			repeat (3) @(negedge clk);
			chk("slow for feature", slowOscEnable, 1);
		end
		@(posedge clk);
		portBit6OutEn <= 1'b1;
		portBit6Out <= 1'b1;
		repeat (4) @(negedge clk);
		chk("pin drive", {oscOutPinOe, oscOutPinO}, 2'b11);
		@(posedge clk);
		portBit6OutEn <= 1'b0;
		extPin <= 1'b1;
		repeat (4) @(negedge clk);
		chk("pin input", {oscOutPinOe, portBit6In}, 2'b01);
		apb(1, `OCS_OFS_TUNING, 32'h0f);
		repeat (30) @(negedge clk);
		chk("slow trim early", slowTrim, 0);
		// fast trim moves one code per ten cycles at the scaled settle time
		repeat (290) @(negedge clk);
		chk("trims max", {fastTrim, slowTrim}, 10'h1ef);
		apb(1, `OCS_OFS_TUNING, 32'h10);
		repeat (320) @(negedge clk);
		chk("trims min", {fastTrim, slowTrim}, 10'h210);
		apb(0, `OCS_OFS_TUNING, 0);
		chk("tuning readback", rd, 32'h10);
		endOfTest;
	end
endmodule // ocs_clock_sel_tb_top
